/* File: inc/pds_pkg.sv */
// package for the port direction select block (ports 4 to 7)
// assumes a 32-bit apb master on the same clock
package pds_pkg;
  // ==========================================================
  // register map: printed offsets are word indices, byte address is four times the index
  localparam logic [11:0] PDS_P45_DIR_IDX   = 12'hfea;
  localparam logic [11:0] PDS_P67_DIR_IDX   = 12'hfec;
  localparam logic [13:0] PDS_P45_DIR_ADDR  = {PDS_P45_DIR_IDX, 2'b00};
  localparam logic [13:0] PDS_P67_DIR_ADDR  = {PDS_P67_DIR_IDX, 2'b00};
  // ==========================================================
  // field positions and reset values
  localparam int          PDS_LO_NIB_LSB    = 0;
  localparam int          PDS_HI_NIB_LSB    = 4;
  localparam logic [7:0]  PDS_DIR_RESET     = 8'h00;
  localparam logic [31:0] PDS_READ_VALUE    = 32'h0000_0000;
  localparam logic [3:0]  PDS_FULL_STRB     = 4'h1;

  // pin directions of all four ports
  typedef struct packed {
    logic [3:0] p7;
    logic [3:0] p6;
    logic [3:0] p5;
    logic [3:0] p4;
  } pds_dir_t;

  // whole state of the block
  typedef struct packed {
    logic [7:0]  p45;
    logic [7:0]  p67;
    logic        ready;
    logic        slverr;
    pds_dir_t    dir;
    logic [15:0] pdata;
  } pds_state_t;
endpackage : pds_pkg

/* File: verilog/pds_port_dir.sv */
// port direction select registers for ports 4, 5, 6 and 7
// assumes an apb master on clk_in; output enables feed the pad drivers
//
// Behaviour
// - bit 0 input, bit 1 drives output
// - first register bits 7:4 steer port 5
// - first register bits 3:0 steer port 4
// - second register bits 7:4 steer port 7
// - second register bits 3:0 steer port 6
`timescale 1ns/1ps
module pds_port_dir
  import pds_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [13:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic [3:0]  pstrb_in,
  input  wire logic [15:0] port_data_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic      [15:0] pin_oe_out,
  output logic      [15:0] pin_data_out
);
  // ==========================================================
  // state
  // the whole block state is one packed struct: the two
  // direction bytes as written, the per-pin enables as a
  // registered copy, the retimed latch value and the two
  // bus answer flags
  pds_state_t  state;      // registered state
  pds_state_t  next_state; // value for the next edge
  logic        setup;      // apb setup phase on the bus
  logic        access;     // apb access phase being answered
  logic        hit45;      // address selects the port 4/5 byte
  logic        hit67;      // address selects the port 6/7 byte
  logic        full;       // write carries the low byte lane

  // ==========================================================
  // address decode
  // the whole address is compared, so aliases of the two
  // registers elsewhere in the map answer with an error
  // instead of silently turning pins into outputs
  assign setup  = psel_in && !penable_in;
  assign access = psel_in && penable_in && state.ready;
  assign hit45  = (paddr_in == PDS_P45_DIR_ADDR);
  assign hit67  = (paddr_in == PDS_P67_DIR_ADDR);
  // only a write that carries the low byte is accepted
  assign full   = (pstrb_in[0] == PDS_FULL_STRB[0]);

  // ==========================================================
  // next state
  // no wait state per access: the answer is raised at the
  // edge after setup, and the write lands at the access edge
  // that samples it, and the pins turn at that same edge
  always_comb begin
    next_state        = state;
    // answer and error are pulses, both cleared outside setup
    next_state.ready  = setup;
    next_state.slverr = setup && !(hit45 || hit67);
    if (access && pwrite_in && full) begin
      if (hit45) begin
        next_state.p45 = pwdata_in[7:0];
      end
      if (hit67) begin
        next_state.p67 = pwdata_in[7:0];
      end
    end
    // direction bits map nibble for nibble onto pins
    next_state.dir.p4 = next_state.p45[PDS_LO_NIB_LSB +: 4];
    next_state.dir.p5 = next_state.p45[PDS_HI_NIB_LSB +: 4];
    next_state.dir.p6 = next_state.p67[PDS_LO_NIB_LSB +: 4];
    next_state.dir.p7 = next_state.p67[PDS_HI_NIB_LSB +: 4];
    // the latch value is retimed so the pad sees a flop
    next_state.pdata  = port_data_in;
  end

  // ==========================================================
  // registers
  // asynchronous reset puts every pin into input mode at
  // once, before any clock edge, so no pad fights the board
  // while the clock is still settling
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state     <= '0;
      state.p45 <= PDS_DIR_RESET;
      state.p67 <= PDS_DIR_RESET;
    end else begin
      state     <= next_state;
    end
  end

  // ==========================================================
  // outputs
  // pin map, same packing on all three 16-bit pin buses:
  //   bits 3:0   port 4 pins 3:0, first register bits 3:0
  //   bits 7:4   port 5 pins 3:0, first register bits 7:4
  //   bits 11:8  port 6 pins 3:0, second register bits 3:0
  //   bits 15:12 port 7 pins 3:0, second register bits 7:4
  // an enable of 1 drives the pin from the latch, 0 floats it
  // the registers are write-only, so reads cost no mux; the
  // limitation is that software must keep its own shadow copy
  assign pready_out   = state.ready;
  assign pslverr_out  = state.slverr;
  assign prdata_out   = PDS_READ_VALUE; // write-only, reads zero
  assign pin_oe_out   = state.dir;
  assign pin_data_out = state.pdata;

  // ==========================================================
  // checks
  property p_reset_input;
    @(posedge clk_in) rst_in |=> (pin_oe_out == 16'h0000);
  endproperty
  a_reset_input: assert property (p_reset_input) else $error("pins not inputs after reset");

  sequence s_wr45;
    psel_in && penable_in && pready_out && pwrite_in && hit45 && full;
  endsequence
  sequence s_wr67;
    psel_in && penable_in && pready_out && pwrite_in && hit67 && full;
  endsequence

  property p_p5;
    @(posedge clk_in) disable iff (rst_in) s_wr45 |=> pin_oe_out[7:4] == $past(pwdata_in[7:4]);
  endproperty
  a_p5: assert property (p_p5) else $error("port 5 direction wrong");
  property p_p4;
    @(posedge clk_in) disable iff (rst_in) s_wr45 |=> pin_oe_out[3:0] == $past(pwdata_in[3:0]);
  endproperty
  a_p4: assert property (p_p4) else $error("port 4 direction wrong");
  property p_p7;
    @(posedge clk_in) disable iff (rst_in) s_wr67 |=> pin_oe_out[15:12] == $past(pwdata_in[7:4]);
  endproperty
  a_p7: assert property (p_p7) else $error("port 7 direction wrong");
  property p_p6;
    @(posedge clk_in) disable iff (rst_in) s_wr67 |=> pin_oe_out[11:8] == $past(pwdata_in[3:0]);
  endproperty
  a_p6: assert property (p_p6) else $error("port 6 direction wrong");
  property p_partial;
    @(posedge clk_in) disable iff (rst_in)
      (psel_in && penable_in && pready_out && !full) |=> $stable(pin_oe_out);
  endproperty
  a_partial: assert property (p_partial) else $error("partial write changed direction");
  property p_read_zero;
    @(posedge clk_in) disable iff (rst_in) pready_out |-> prdata_out == 32'h0000_0000;
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("read returned data");
  property p_hold;
    @(posedge clk_in) disable iff (rst_in)
      !(psel_in && penable_in && pwrite_in) |=> $stable(pin_oe_out);
  endproperty
  a_hold: assert property (p_hold) else $error("direction changed without write");
  property p_ready_one_wait;
    @(posedge clk_in) disable iff (rst_in) (psel_in && !penable_in) |=> pready_out;
  endproperty
  a_ready_one_wait: assert property (p_ready_one_wait) else $error("pready not after setup");

  // ==========================================================
  // bus handshake checks
  // transfer walk, one line per edge:
  //   edge 1  setup sampled, answer flags computed
  //   edge 2  access sampled with pready high, write lands, pready low again, new enables on the pins
  // a master that keeps penable up past the answer is not
  // answered twice, since pready only follows a setup phase
  sequence s_setup;
    psel_in && !penable_in;
  endsequence
  sequence s_unmapped_setup;
    psel_in && !penable_in && !hit45 && !hit67;
  endsequence
  sequence s_mapped_setup;
    psel_in && !penable_in && (hit45 || hit67);
  endsequence
  sequence s_read_access;
    psel_in && penable_in && pready_out && !pwrite_in;
  endsequence
  sequence s_err_access;
    psel_in && penable_in && pready_out && pslverr_out;
  endsequence

  // the answer pulse lasts exactly one cycle
  property p_ready_pulse;
    @(posedge clk_in) disable iff (rst_in) pready_out |=> !pready_out;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready held past one cycle");

  // no answer without a setup phase one edge earlier
  property p_ready_after_setup;
    @(posedge clk_in) disable iff (rst_in) pready_out |-> $past(psel_in && !penable_in);
  endproperty
  a_ready_after_setup: assert property (p_ready_after_setup) else $error("pready without setup");

  // a setup phase is never itself answered
  property p_setup_not_ready;
    @(posedge clk_in) disable iff (rst_in) s_setup |-> !pready_out;
  endproperty
  a_setup_not_ready: assert property (p_setup_not_ready) else $error("pready during setup");

  // ==========================================================
  // error answer checks
  // the error flag only ever rides on the answer pulse
  property p_err_with_ready;
    @(posedge clk_in) disable iff (rst_in) pslverr_out |-> pready_out;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr without pready");

  // an address outside the map answers with an error
  property p_err_unmapped;
    @(posedge clk_in) disable iff (rst_in) s_unmapped_setup |=> pslverr_out;
  endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not refused");

  // either register answers cleanly
  property p_err_mapped;
    @(posedge clk_in) disable iff (rst_in) s_mapped_setup |=> !pslverr_out;
  endproperty
  a_err_mapped: assert property (p_err_mapped) else $error("mapped access refused");

  // a refused write leaves every pin as it was
  property p_err_keeps;
    @(posedge clk_in) disable iff (rst_in) s_err_access |=> $stable(pin_oe_out);
  endproperty
  a_err_keeps: assert property (p_err_keeps) else $error("refused write changed direction");

  // ==========================================================
  // direction register checks
  // a read has no side effect on the pins
  property p_read_keeps;
    @(posedge clk_in) disable iff (rst_in) s_read_access |=> $stable(pin_oe_out);
  endproperty
  a_read_keeps: assert property (p_read_keeps) else $error("read changed direction");

  // a write to one register leaves the other pin group alone
  property p_wr45_keeps67;
    @(posedge clk_in) disable iff (rst_in) s_wr45 |=> $stable(pin_oe_out[15:8]);
  endproperty
  a_wr45_keeps67: assert property (p_wr45_keeps67) else $error("port 6/7 changed by first register");
  property p_wr67_keeps45;
    @(posedge clk_in) disable iff (rst_in) s_wr67 |=> $stable(pin_oe_out[7:0]);
  endproperty
  a_wr67_keeps45: assert property (p_wr67_keeps45) else $error("port 4/5 changed by second register");

  // a change of direction is always caused by an answered write
  property p_oe_cause;
    @(posedge clk_in) disable iff (rst_in)
      !$stable(pin_oe_out) |-> $past(psel_in && penable_in && pready_out && pwrite_in);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("direction changed with no write");

  // ==========================================================
  // pad and reset checks
  // the pad data is the latch value one edge late
  property p_pin_data;
    @(posedge clk_in) disable iff (rst_in) 1'b1 |=> pin_data_out == $past(port_data_in);
  endproperty
  a_pin_data: assert property (p_pin_data) else $error("pad data not the latch value");

  // reset clears the pad data and leaves the bus quiet
  property p_reset_quiet;
    @(posedge clk_in) rst_in |=> (pin_data_out == 16'h0000) && !pready_out && !pslverr_out;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
endmodule : pds_port_dir

/* File: dv/tb_top.sv */
// testbench for the port direction registers of ports 4 to 7
// assumes pds_pkg compiled first; apb master and port data driven here
`timescale 1ns/1ps
module tb_top;
  import pds_pkg::*;
  // ==========================================================
  // stimulus signals, all valid from time zero
  logic        clk_in = 0, rst_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0;
  logic [13:0] paddr_in = 0;
  logic [31:0] pwdata_in = 0;
  logic [3:0]  pstrb_in = 0;
  logic [15:0] port_data_in = 0;
  logic [31:0] prdata_out;
  logic        pready_out, pslverr_out;
  logic [15:0] pin_oe_out, pin_data_out;
  logic [7:0]  e45 = 0, e67 = 0;
  logic [16:0] exp_q[$];
  logic [16:0] note;
  integer      seed = 32'h89c5fb38, miscompares = 0, tests_run = 0, cycles = 0, i;

  pds_port_dir i_dut (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in),
    .port_data_in(port_data_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .pin_oe_out(pin_oe_out), .pin_data_out(pin_data_out));

  always #10 clk_in = ~clk_in;
  // ==========================================================
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      miscompares++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, want);
    end
  endtask : check
  // one apb transfer; the expectation is noted at setup, the bench model updated only for valid full writes
  task automatic apb(input logic wr, input logic [13:0] a, input logic [31:0] d, input logic [3:0] s);
    logic err;
    err = (a !== PDS_P45_DIR_ADDR) && (a !== PDS_P67_DIR_ADDR);
    @(posedge clk_in);
    psel_in <= 1; pwrite_in <= wr; paddr_in <= a; pwdata_in <= d; pstrb_in <= s;
    if (wr && !err && s[0]) begin
      if (a === PDS_P45_DIR_ADDR) e45 = d[7:0];
      else e67 = d[7:0];
    end
    exp_q.push_back({err, e67, e45});
    @(posedge clk_in);
    penable_in <= 1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    psel_in <= 0;
    penable_in <= 0;
  endtask : apb
  task give_verdict;
    $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  // ==========================================================
  // monitor: oldest note is compared when the answer appears
  always @(posedge clk_in) begin
    if (pready_out === 1'b1 && exp_q.size() > 0) begin
      note = exp_q.pop_front();
      check({31'h0, pslverr_out}, {31'h0, note[16]});
      check(prdata_out, PDS_READ_VALUE);
      #1 check({16'h0, pin_oe_out}, {16'h0, note[15:0]});
    end
  end
  // hang guard, well above the sixty or so cycles needed
  always @(posedge clk_in) begin
    cycles++;
    if (cycles > 3000) begin
      miscompares++;
      give_verdict;
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    port_data_in <= $random(seed);
    repeat (3) @(posedge clk_in);
    rst_in <= 0;
    check({16'h0, pin_oe_out}, 32'h0);
    for (i = 0; i < 10; i++) apb(1, i[0] ? PDS_P67_DIR_ADDR : PDS_P45_DIR_ADDR, $random(seed), 4'h1);
    apb(1, PDS_P45_DIR_ADDR, 32'hff, 4'h1);
    apb(1, PDS_P67_DIR_ADDR, 32'hff, 4'h1);
    apb(1, PDS_P45_DIR_ADDR, 32'h00, 4'he);
    $display("test random and boundary writes done");
    apb(1, 14'h3fb8, 32'h00, 4'h1);
    apb(1, 14'h3fa9, 32'hff, 4'h1);
    apb(0, PDS_P67_DIR_ADDR, 32'h0, 4'h0);
    $display("test refused accesses and reads done");
    @(posedge clk_in) port_data_in <= $random(seed);
    @(posedge clk_in) #1 check({16'h0, pin_data_out}, {16'h0, port_data_in});
    @(posedge clk_in);
    rst_in <= 1;
    #1 check({16'h0, pin_oe_out}, 32'h0);
    @(posedge clk_in);
    rst_in <= 0;
    e45 = 0;
    e67 = 0;
    apb(1, PDS_P67_DIR_ADDR, 32'h5a, 4'h1);
    $display("test mid-run reset done");
    give_verdict;
  end
endmodule : tb_top
